// ===== udf_dma_top.sv
// Multi-channel DMA between system memory and USB endpoint FIFOs.
// Assumes one memory slave, per-channel endpoint FIFO status, one clock.
// Operation
// - Multi-packet transmit fills the FIFO in max-packet-size chunks.
// - Auto-arm sends each full max-size packet with no software action.
// - Channel completion raises the common USB interrupt; status apart.
// - Reading interrupt status clears all pending channel flags at once.
// - Receive auto-ack acknowledges after the last FIFO word is read.
// - Endpoint DMA enabled suppresses the endpoint receive interrupt.
// - Multi-packet receive starts moving only after a full packet.
// - Short packet in multi-packet receive: no start, interrupt still raised.
// - Host auto-request issues new IN requests during multi-packet receive.
// - Each channel has its own completion interrupt enable.
// - Global status is readable and cleared by a status-clear write.
// - Memory accesses use only word-aligned addresses.
// - Burst length per channel: none, 4, 8 or 16 words.
// - Multi-packet mode flags once per transfer, single mode per packet.
// - Direction selects FIFO-to-memory receive or memory-to-FIFO transmit.
`timescale 1ns/1ps
`default_nettype none
module udf_dma_top import udf_pkg::*; #(
    parameter int NCH = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output udf_mem_req_type mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic [NCH-1:0] fifo_space,
    input wire logic [NCH-1:0] fifo_avail,
    input wire logic [31:0] fifo_rdata,
    output logic fifo_push,
    output logic fifo_pop,
    output logic [31:0] fifo_wdata,
    output logic [((NCH > 1) ? $clog2(NCH) : 1)-1:0] fifo_ch,
    input wire logic [NCH-1:0] ep_rx_pkt,
    input wire logic [NCH-1:0] ep_rx_full_pkt,
    input wire logic [NCH-1:0] ep_rx_short,
    output logic tx_arm,
    output logic rx_ack,
    output logic host_in_request,
    output logic [NCH-1:0] ep_rx_irq,
    output logic usb_irq
);
    localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;

    udf_state_type state_q, state_d;
    logic [CH_W-1:0] ch_q, pick;
    logic [31:0] addr_q [NCH];
    logic [31:0] cnt_q [NCH];
    udf_ctrl_type ctrl_q [NCH];
    logic [MPS_W-1:0] mps_q [NCH];
    logic [MPS_W-1:0] pkt_q [NCH];
    logic [NCH-1:0] pend_q, err_q, go, ien, rxi_q;
    logic irq_q;
    logic [4:0] words_q, blen;
    logic [31:0] data_q, rdata_q, rdata_d;
    logic wr_q, rd_clr, acc, step, stay, pkt_end;
    logic [11:0] wofs_q;
    logic [2:0] bytes;
    logic [31:0] new_cnt;
    logic [MPS_W-1:0] new_pkt;
    udf_ctrl_type cur;
    udf_mem_req_type req_q;
    logic push_q, pop_q, arm_q, ack_q, inreq_q;

    assign hrdata = rdata_q;
    assign mem_req = req_q;
    assign fifo_push = push_q;
    assign fifo_pop = pop_q;
    assign fifo_wdata = data_q;
    assign fifo_ch = ch_q;
    assign tx_arm = arm_q;
    assign rx_ack = ack_q;
    assign host_in_request = inreq_q;
    assign ep_rx_irq = rxi_q;
    assign usb_irq = irq_q;

    // ------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    assign acc = hsel && hready && htrans[1];
    assign rd_clr = acc && !hwrite && haddr[11:0] == OFS_INTSTAT;

    // Fixed answer: no stalls, no errors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Write address held into the data phase, where hwdata stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wofs_q <= '0;
        end else begin
            wr_q <= acc && hwrite;
            wofs_q <= haddr[11:0];
        end
    end

    // Read mux, sampled in the address phase
    always_comb begin
        rdata_d = '0;
        if (!haddr[GLOBAL_BIT]) begin
            if (int'(haddr[GLOBAL_BIT-1:CH_LSB]) < NCH) begin
                case (haddr[REG_LSB +: 2])
                    REG_ADDR: rdata_d = addr_q[haddr[CH_LSB +: CH_W]];
                    REG_COUNT: rdata_d = cnt_q[haddr[CH_LSB +: CH_W]];
                    REG_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q[haddr[CH_LSB +: CH_W]];
                    default: rdata_d[MPS_W-1:0] = mps_q[haddr[CH_LSB +: CH_W]];
                endcase
            end
        end else begin
            case (haddr[11:0])
                OFS_INTSTAT: rdata_d[NCH-1:0] = pend_q;
                OFS_STATUS: begin
                    rdata_d[NCH-1:0] = err_q;
                    rdata_d[BUSY_BIT] = state_q != ST_IDLE;
                end
                OFS_NUMCH: rdata_d = 32'(NCH);
                default: rdata_d = '0;
            endcase
        end
    end

    // Read data register; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= '0;
        end else if (acc && !hwrite) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Active channel datapath
    // ------------------------------------------------------------
    assign cur = ctrl_q[ch_q];
    assign step = state_q == ST_STEP;
    // Tail word may carry fewer than four bytes
    assign bytes = (cnt_q[ch_q] < WORD_BYTES) ? cnt_q[ch_q][2:0] : WORD_BYTES_3;
    assign new_cnt = cnt_q[ch_q] - {29'h0, bytes};
    assign new_pkt = pkt_q[ch_q] + {{(MPS_W-3){1'b0}}, bytes};
    // packet boundary at max packet size
    assign pkt_end = new_pkt >= mps_q[ch_q] || new_cnt == '0;

    always_comb begin
        case (cur.burst)
            BURST_NONE: blen = BLEN_1;
            BURST_4: blen = BLEN_4;
            BURST_8: blen = BLEN_8;
            default: blen = BLEN_16;
        endcase
    end
    assign stay = !pkt_end && cur.enable && (words_q + 5'h01) < blen;

    // Lowest ready channel wins; fairness traded for small logic
    always_comb begin
        pick = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (go[i]) pick = CH_W'(i);
        end
    end

    // Engine sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (|go) state_d = ctrl_q[pick].dir_tx ? ST_MEM : ST_FIFO;
            ST_MEM: if (mem_ack) state_d = cur.dir_tx ? ST_FIFO : ST_STEP;
            ST_FIFO: begin
                if (cur.dir_tx ? fifo_space[ch_q] : fifo_avail[ch_q]) begin
                    state_d = cur.dir_tx ? ST_STEP : ST_MEM;
                end
            end
            ST_STEP: begin
                if (stay) state_d = cur.dir_tx ? ST_MEM : ST_FIFO;
                else state_d = ST_IDLE;
            end
        endcase
    end

    // State, channel and burst word count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            ch_q <= '0;
            words_q <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && |go) begin
                ch_q <= pick;
                words_q <= '0;
            end else if (step) begin
                words_q <= words_q + 5'h01;
            end
        end
    end

    // direction picks read or write; aligned address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else begin
            req_q.valid <= state_d == ST_MEM;
            if (state_d == ST_MEM && !req_q.valid) begin
                // Entry from idle must use the newly picked channel
                req_q.write <= state_q == ST_IDLE ? !ctrl_q[pick].dir_tx
                               : !cur.dir_tx;
                req_q.addr <= step ? addr_q[ch_q] + WORD_BYTES
                            : (state_q == ST_IDLE ? addr_q[pick] : addr_q[ch_q]);
                req_q.addr[1:0] <= 2'b00;
                req_q.wdata <= fifo_rdata;
            end
        end
    end

    // Word holding register and FIFO strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= '0;
            push_q <= 1'b0;
            pop_q <= 1'b0;
        end else begin
            push_q <= state_q == ST_FIFO && cur.dir_tx && fifo_space[ch_q];
            pop_q <= state_q == ST_FIFO && !cur.dir_tx && fifo_avail[ch_q];
            if (state_q == ST_MEM && mem_ack) data_q <= mem_rdata;
        end
    end

    // Endpoint side pulses, one cycle after the step, and the registered USB interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_q <= 1'b0;
            ack_q <= 1'b0;
            inreq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // auto-arm only a full max-size packet
            arm_q <= step && cur.dir_tx && cur.tx_auto_arm
                     && new_pkt == mps_q[ch_q];
            // ack once the packet's last word is out
            ack_q <= step && !cur.dir_tx && cur.rx_auto_ack && pkt_end;
            // ask for the next packet while bytes remain
            inreq_q <= step && !cur.dir_tx && cur.multi_packet
                       && cur.host_auto_in_request
                       && new_pkt == mps_q[ch_q] && new_cnt != '0;
            irq_q <= |(pend_q & ien);
        end
    end

    // ------------------------------------------------------------
    // Per-channel registers and flags
    // ------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : gen_ch
        logic sel, hit, done;
        assign sel = wr_q && !wofs_q[GLOBAL_BIT]
                     && int'(wofs_q[GLOBAL_BIT-1:CH_LSB]) == i;
        assign hit = step && ch_q == CH_W'(i);
        // count exhausted; single mode per packet too
        assign done = hit && (new_cnt == '0 || (!cur.multi_packet && pkt_end));
        assign ien[i] = ctrl_q[i].irq_en;
        // multi-packet receive waits for a full packet
        assign go[i] = ctrl_q[i].enable && cnt_q[i] != '0
                       && (ctrl_q[i].dir_tx || !ctrl_q[i].multi_packet
                           || pkt_q[i] != '0 || ep_rx_full_pkt[i]);

        // Engine update after the bus write, so the engine wins
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                addr_q[i] <= '0;
                cnt_q[i] <= '0;
                ctrl_q[i] <= '0;
                mps_q[i] <= MPS_RESET;
                pkt_q[i] <= '0;
            end else begin
                if (sel) begin
                    case (wofs_q[REG_LSB +: 2])
                        REG_ADDR: addr_q[i] <= {hwdata[31:2], 2'b00};
                        REG_COUNT: cnt_q[i] <= hwdata;
                        REG_CTRL: ctrl_q[i] <= hwdata[CTRL_W-1:0];
                        default: mps_q[i] <= hwdata[MPS_W-1:0];
                    endcase
                    pkt_q[i] <= '0;
                end
                if (hit) begin
                    addr_q[i] <= addr_q[i] + WORD_BYTES;
                    cnt_q[i] <= new_cnt;
                    pkt_q[i] <= pkt_end ? '0 : new_pkt;
                    if (new_cnt == '0) ctrl_q[i].enable <= 1'b0;
                end
            end
        end

        // Sticky pend and error flags: a new event beats a clear in the same cycle
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pend_q[i] <= 1'b0;
                err_q[i] <= 1'b0;
                rxi_q[i] <= 1'b0;
            end else begin
                pend_q[i] <= done || (pend_q[i] && !rd_clr);
                err_q[i] <= (sel && wofs_q[REG_LSB +: 2] == REG_ADDR
                             && hwdata[1:0] != 2'b00)
                            || (err_q[i] && !(wr_q && wofs_q == OFS_STATUS
                                              && hwdata[i]));
                // hidden under endpoint DMA; a short packet still shows in multi-packet mode
                rxi_q[i] <= ep_rx_pkt[i] && (!ctrl_q[i].endpoint_dma_en
                            || (ctrl_q[i].multi_packet && ep_rx_short[i]));
            end
        end

        property p_rx_suppress;
            @(posedge hclk) disable iff (!hresetn)
            ctrl_q[i].endpoint_dma_en && !ep_rx_short[i] |=> !rxi_q[i];
        endproperty
        a_rx_suppress: assert property (p_rx_suppress)
            else $error("receive interrupt not suppressed");
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_align;
        @(posedge hclk) disable iff (!hresetn)
        req_q.valid |-> req_q.addr[1:0] == 2'b00;
    endproperty
    a_align: assert property (p_align)
        else $error("unaligned memory access");

    property p_irq_fwd;
        @(posedge hclk) disable iff (!hresetn)
        (pend_q & ien) != '0 |=> usb_irq;
    endproperty
    a_irq_fwd: assert property (p_irq_fwd)
        else $error("enabled pending flag not forwarded");

    property p_irq_mask;
        @(posedge hclk) disable iff (!hresetn)
        (pend_q & ien) == '0 |=> !usb_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("disabled channel raised interrupt");

    property p_rd_clear;
        @(posedge hclk) disable iff (!hresetn)
        rd_clr && !step |=> pend_q == '0;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("status read did not clear flags");

    // Any channel register write in its data phase
    function automatic logic sel_any();
        return wr_q && !wofs_q[GLOBAL_BIT];
    endfunction

    property p_count;
        @(posedge hclk) disable iff (!hresetn)
        step && !sel_any() |=> cnt_q[$past(ch_q)] == $past(new_cnt);
    endproperty
    a_count: assert property (p_count)
        else $error("count not decremented");

    property p_done;
        @(posedge hclk) disable iff (!hresetn)
        step && new_cnt == '0 |=> pend_q[$past(ch_q)];
    endproperty
    a_done: assert property (p_done)
        else $error("completion flag not set");

    property p_burst;
        @(posedge hclk) disable iff (!hresetn)
        state_q != ST_IDLE |-> words_q < blen;
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst length exceeded");

    property p_arm;
        @(posedge hclk) disable iff (!hresetn)
        tx_arm |-> $past(step) && $past(new_pkt == mps_q[ch_q]);
    endproperty
    a_arm: assert property (p_arm)
        else $error("auto-arm on a packet not of max size");

    property p_m1_start;
        @(posedge hclk) disable iff (!hresetn)
        state_q == ST_IDLE && state_d == ST_FIFO
        && ctrl_q[pick].multi_packet && pkt_q[pick] == '0
        |-> ep_rx_full_pkt[pick];
    endproperty
    a_m1_start: assert property (p_m1_start)
        else $error("receive started without full packet");
endmodule // udf_dma_top
`default_nettype wire

// ===== udf_dma_top_tb_top.sv
// Self-checking bench: register bus tasks drive transfers end to end.
// Assumes udf_dma_top with four channels and the udf_far_model partner.
`timescale 1ns/1ps
`default_nettype none
module udf_dma_top_tb_top import udf_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp, slow, mem_ack;
    logic fifo_push, fifo_pop, tx_arm, rx_ack, host_in_request, usb_irq;
    logic [1:0] htrans, fifo_ch;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, mem_rdata, fifo_rdata, fifo_wdata, v;
    logic [3:0] fifo_space, fifo_avail, ep_rx_pkt, ep_rx_full_pkt;
    logic [3:0] ep_rx_short, ep_rx_irq;
    udf_mem_req_type mem_req;
    int num_errors = 0, comparisons = 0, arm_n = 0, ack_n = 0, cyc = 0;
    int inreq_n = 0;
    assign hready = hreadyout;
    always #25 hclk = ~hclk;
    udf_dma_top #(.NCH(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .fifo_space(fifo_space),
        .fifo_avail(fifo_avail), .fifo_rdata(fifo_rdata),
        .fifo_push(fifo_push), .fifo_pop(fifo_pop), .fifo_wdata(fifo_wdata),
        .fifo_ch(fifo_ch), .ep_rx_pkt(ep_rx_pkt),
        .ep_rx_full_pkt(ep_rx_full_pkt), .ep_rx_short(ep_rx_short),
        .tx_arm(tx_arm), .rx_ack(rx_ack), .host_in_request(host_in_request),
        .ep_rx_irq(ep_rx_irq), .usb_irq(usb_irq));
    udf_far_model #(.NCH(4)) model (.hclk(hclk), .hresetn(hresetn),
        .slow(slow), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .fifo_space(fifo_space),
        .fifo_avail(fifo_avail), .fifo_rdata(fifo_rdata),
        .fifo_push(fifo_push), .fifo_pop(fifo_pop), .fifo_wdata(fifo_wdata),
        .fifo_ch(fifo_ch));
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    // Single word transfer; address phase held until hready
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        v = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    // Bounded wait; a hang shows up as a failed interrupt compare
    task automatic wait_irq;
        for (int n = 0; n < 2000 && usb_irq !== 1'b1; n++) @(posedge hclk);
        repeat (4) @(posedge hclk);
    endtask
    // Pulse counters and run ceiling
    always @(posedge hclk) begin
        cyc++;
        if (tx_arm === 1'b1) arm_n++;
        if (rx_ack === 1'b1) ack_n++;
        if (host_in_request === 1'b1) inreq_n++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {hresetn, hwrite, slow} = 3'h0;
        hsel = 1'b1;
        htrans = 2'h0;
        hsize = 3'h2;
        {haddr, hwdata} = 64'h0;
        {ep_rx_pkt, ep_rx_full_pkt, ep_rx_short} = 12'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'h0C); chk(v, {21'h0, MPS_RESET});
        rd(32'h208); chk(v, 32'h4);
        rd(32'h300); chk(v, 32'h0);
        chk({30'h0, hresp, hready}, 32'h1);
        // Multi-packet transmit, auto-arm, slow memory and stalling FIFO
        slow <= 1'b1;
        wr(32'h00, 32'h100);
        wr(32'h04, 32'h10); // whole packets, no tail
        wr(32'h0C, 32'h8);
        wr(32'h08, 32'hBB); // four-word bursts, cut at each two-word packet
        wait_irq();
        chk({31'h0, usb_irq}, 32'h1);
        chk(32'(model.txq.size()), 32'h4);
        for (int i = 0; i < 4; i++) begin
            chk(model.txq[i], 32'hA500_0040 + i);
        end
        chk(32'(arm_n), 32'h2);
        rd(32'h00); chk(v, 32'h110);
        rd(32'h04); chk(v, 32'h0);
        rd(32'h08); chk(v, 32'hBA);
        rd(32'h200); chk(v, 32'h1);
        rd(32'h200); chk(v, 32'h0);
        @(posedge hclk);
        chk({31'h0, usb_irq}, 32'h0);
        // Single-packet receive on channel 1 with auto-ack
        slow <= 1'b0;
        model.rxq = '{32'h1234_5678, 32'h9ABC_DEF0}; // data first
        wr(32'h10, 32'h80);
        wr(32'h14, 32'h8);
        wr(32'h18, 32'h121); // auto-ack, never stalled
        wait_irq();
        chk(model.mem[32], 32'h1234_5678);
        chk(model.mem[33], 32'h9ABC_DEF0);
        chk(32'(ack_n), 32'h1);
        rd(32'h200); chk(v, 32'h2);
        // Multi-packet receive of two one-word packets, host auto-request
        model.rxq = '{32'h0BAD_F00D, 32'h600D_CAFE};
        wr(32'h10, 32'h90);
        wr(32'h1C, 32'h4);
        wr(32'h14, 32'h8);
        wr(32'h18, 32'h211); // armed before the full-packet flag
        repeat (20) @(posedge hclk);
        chk(32'(model.rxq.size()), 32'h2);
        ep_rx_full_pkt <= 4'h2;
        for (int n = 0; n < 50; n++) begin
            rd(32'h18);
            if (v[0] === 1'b0) break;
        end
        chk(model.mem[36], 32'h0BAD_F00D);
        chk(model.mem[37], 32'h600D_CAFE);
        chk(32'(inreq_n), 32'h1);
        chk(32'(ack_n), 32'h1);
        chk({31'h0, usb_irq}, 32'h0);
        rd(32'h200); chk(v, 32'h2);
        ep_rx_full_pkt <= 4'h0;
        // Misaligned address is stored aligned and flagged
        wr(32'h20, 32'h103);
        rd(32'h20); chk(v, 32'h100);
        rd(32'h204); chk(v, 32'h4);
        wr(32'h204, 32'h4);
        rd(32'h204); chk(v, 32'h0);
        // Endpoint receive interrupt under endpoint DMA
        ep_rx_pkt <= 4'h2;
        wr(32'h18, 32'h40);
        repeat (3) @(posedge hclk);
        chk({28'h0, ep_rx_irq}, 32'h0);
        ep_rx_short <= 4'h2; // short packet left to software
        wr(32'h18, 32'h50);
        repeat (3) @(posedge hclk);
        chk({28'h0, ep_rx_irq}, 32'h2);
        wr(32'h18, 32'h0);
        repeat (3) @(posedge hclk);
        chk({28'h0, ep_rx_irq}, 32'h2);
        report_and_stop();
    end
endmodule // udf_dma_top_tb_top
`default_nettype wire

// ===== udf_far_model.sv
// Far side model: word memory, a channel 0 transmit FIFO and a channel 1 receive FIFO.
// Assumes the memory and FIFO handshakes of udf_dma_top, one clock.
`timescale 1ns/1ps
`default_nettype none
module udf_far_model import udf_pkg::*; #(
    parameter int NCH = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire udf_mem_req_type mem_req,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic [NCH-1:0] fifo_space,
    output logic [NCH-1:0] fifo_avail = '0,
    output logic [31:0] fifo_rdata = 32'h0,
    input wire logic fifo_push,
    input wire logic fifo_pop,
    input wire logic [31:0] fifo_wdata,
    input wire logic [$clog2(NCH)-1:0] fifo_ch
);
    logic [31:0] mem [0:255];
    logic [31:0] txq [$];
    logic [31:0] rxq [$];
    logic [1:0] wait_q;
    logic stall_q = 1'b0;
    logic [7:0] idx;
    assign idx = mem_req.addr[9:2];
    assign fifo_space = {NCH{~stall_q}};
    // Known fill so loads can be checked
    initial for (int i = 0; i < 256; i++) mem[i] = 32'hA500_0000 + i;
    // one word per ack, slow mode adds two waits
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_ack <= 1'b0;
            wait_q <= 2'h0;
            mem_rdata <= 32'h0;
        end else if (mem_ack) begin
            // Data lines toggle outside the ack so stale data never helps
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.write) mem[idx] <= mem_req.wdata;
        end else if (mem_req.valid && (!slow || wait_q == 2'h2)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[idx];
            wait_q <= 2'h0;
        end else begin
            mem_rdata <= ~mem_rdata;
            if (mem_req.valid) wait_q <= wait_q + 2'h1;
        end
    end
    // channel 0 transmits, channel 1 receives; slow stalls pushes
    always @(posedge hclk) begin
        stall_q <= slow & ~stall_q;
        if (fifo_push && fifo_ch == 0) txq.push_back(fifo_wdata);
        if (fifo_pop && fifo_ch == 1) void'(rxq.pop_front());
        // Only channel 1 ever holds receive words
        fifo_avail <= {{(NCH-2){1'b0}}, rxq.size() > 0, 1'b0};
        fifo_rdata <= (rxq.size() > 0) ? rxq[0] : ~fifo_rdata;
    end
endmodule // udf_far_model
`default_nettype wire

// ===== udf_pkg.sv
// Shared constants and types of the USB endpoint FIFO DMA engine.
// Assumes a 32-bit AHB-Lite register bus and a word-wide memory port.
`default_nettype none
package udf_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] REG_ADDR = 2'h0;
    localparam logic [1:0] REG_COUNT = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    localparam logic [1:0] REG_MPS = 2'h3;
    localparam logic [11:0] OFS_INTSTAT = 12'h200;
    localparam logic [11:0] OFS_STATUS = 12'h204;
    localparam logic [11:0] OFS_NUMCH = 12'h208;
    localparam int GLOBAL_BIT = 9;
    localparam int CH_LSB = 4;
    localparam int REG_LSB = 2;
    localparam int BUSY_BIT = 31;
    localparam int CTRL_W = 10;
    localparam int MPS_W = 11;
    localparam logic [10:0] MPS_RESET = 11'h040;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [2:0] WORD_BYTES_3 = 3'h4;
    // ------------------------------------------------------------
    // Burst codes and their lengths in words
    // ------------------------------------------------------------
    localparam logic [1:0] BURST_NONE = 2'h0;
    localparam logic [1:0] BURST_4 = 2'h1;
    localparam logic [1:0] BURST_8 = 2'h2;
    localparam logic [4:0] BLEN_1 = 5'h01;
    localparam logic [4:0] BLEN_4 = 5'h04;
    localparam logic [4:0] BLEN_8 = 5'h08;
    localparam logic [4:0] BLEN_16 = 5'h10;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic host_auto_in_request;
        logic rx_auto_ack;
        logic tx_auto_arm;
        logic endpoint_dma_en;
        logic irq_en;
        logic multi_packet;
        logic dir_tx;
        logic [1:0] burst;
        logic enable;
    } udf_ctrl_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } udf_mem_req_type;
    typedef enum {ST_IDLE, ST_MEM, ST_FIFO, ST_STEP} udf_state_type;
endpackage
`default_nettype wire
